// >>> rtl/annunciator_defines.svh
// Constants for the twelve-channel alarm annunciator sequencer.
// Assumes a 50 MHz system clock and AXI4-Lite register access.
// Summary of operation
// - Twelve inputs, per-input rest polarity selectable
// - Acknowledge, test, reset operator inputs read
// - Horn relay driven by selected sequence
// - Common relay on active/unreset alarm, polarity configurable
// - Internal fault also trips common relay
// - Linked modules share sequence and first-out
// - One selected sequence governs all channels
// - Automatic, manual and ringback sequences supported
// - Manual steady sequence shows no flashing
// - Auto first-out, no subsequent alarm state
// - Manual first-out, needs reset to clear
// - First-out flashes distinctly, reset clears
// - Serial node settings: baud, parity, stop, address
`ifndef ANNUNCIATOR_DEFINES_SVH
`define ANNUNCIATOR_DEFINES_SVH
`define ADDR_CONFIG 8'h00
`define ADDR_POLARITY 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_INT_MASK 8'h0C
`define ADDR_ALARMS 8'h10
`define ADDR_SERIAL 8'h14
`define CFG_SEQ_LSB 0
`define CFG_COMMON_ENERGIZE_BIT 4
`define CFG_FAULT_BIT 5
`define FLASH_PERIOD_NS 500000000
`define CLOCK_PERIOD_NS 20
`define SERIAL_RESET 32'h0000_00F1
`define BAUD_MIN 4800
`define BAUD_MAX 38400
`define NODE_ADDR_MAX 8'hF7
`endif

// >>> rtl/annunciator_pkg.sv
// Types for the alarm annunciator sequencer.
// Assumes the constants header is included by users.
package annunciator_pkg;
  typedef enum logic [2:0] {
    seq_auto_reset = 3'h0,
    seq_manual_reset = 3'h1,
    seq_ringback = 3'h2,
    seq_manual_steady = 3'h3,
    seq_firstout_auto = 3'h4,
    seq_firstout_manual = 3'h5,
    seq_firstout_flash_reset = 3'h6
  } sequence_t;
  typedef enum logic [1:0] {
    ch_normal = 2'h0,
    ch_unacked = 2'h1,
    ch_acked = 2'h2,
    ch_ringback = 2'h3
  } channel_state_t;
endpackage : annunciator_pkg

// >>> rtl/alarm_annunciator_sequencer.sv
// Alarm annunciator sequencer: per-channel sequence logic, relays, lamps.
// Assumes contacts and pushbuttons already debounced and synchronous.
//
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`include "annunciator_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module alarm_annunciator_sequencer #(
  parameter int CHANNELS = 12,
  parameter int FLASH_CYCLES = `FLASH_PERIOD_NS / `CLOCK_PERIOD_NS
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic [CHANNELS-1:0] alarm_contact_inputs_in,
  input wire logic acknowledge_in,
  input wire logic lamp_test_in,
  input wire logic reset_button_in,
  input wire logic link_alarm_in,
  input wire logic link_firstout_taken_in,
  input wire logic link_ack_in,
  input wire logic link_reset_in,
  output logic link_alarm_out,
  output logic link_firstout_taken_out,
  output logic link_ack_out,
  output logic link_reset_out,
  output logic [CHANNELS-1:0] lamps_out,
  output logic horn_relay_out,
  output logic common_relay_out,
  output logic irq_out,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [31:0] config_q, polarity_q, mask_q, serial_q;
  logic [3:0] status_q;
  logic [CHANNELS-1:0] firstout_q;
  logic firstout_set_q;
  logic [31:0] flash_cnt_q;
  logic flash_q, fast_q;
  logic horn_q;
  logic [CHANNELS-1:0] active_prev_q;
  logic aw_got_q, w_got_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  annunciator_pkg::channel_state_t ch_q [CHANNELS];

  wire annunciator_pkg::sequence_t seq = annunciator_pkg::sequence_t'(config_q[2:0]);
  wire [CHANNELS-1:0] active = alarm_contact_inputs_in ^ polarity_q[CHANNELS-1:0];
  wire ack_cmd = acknowledge_in | link_ack_in;
  wire reset_cmd = reset_button_in | link_reset_in;
  wire is_manual = (seq == annunciator_pkg::seq_manual_reset) |
                   (seq == annunciator_pkg::seq_manual_steady) |
                   (seq == annunciator_pkg::seq_firstout_manual) |
                   (seq == annunciator_pkg::seq_firstout_flash_reset);
  wire is_firstout = config_q[2];
  wire seq_bad = (config_q[2:0] == 3'h7);
  wire fault = seq_bad | config_q[`CFG_FAULT_BIT];
  wire [CHANNELS-1:0] new_trip = active & ~active_prev_q;
  wire firstout_taken = firstout_set_q | link_firstout_taken_in;
  // Lowest index wins ties within one cycle
  wire [CHANNELS-1:0] first_pick = new_trip & ~(new_trip - 1'b1);

  logic [CHANNELS-1:0] unacked, nonnormal, ringing;
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      unacked[i] = (ch_q[i] == annunciator_pkg::ch_unacked);
      ringing[i] = (ch_q[i] == annunciator_pkg::ch_ringback);
      nonnormal[i] = (ch_q[i] != annunciator_pkg::ch_normal);
    end
  end
  wire any_unacked = |unacked;
  wire any_nonnormal = |nonnormal;

  // Per-channel sequence state
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_ch
      annunciator_pkg::channel_state_t nx;
      always_comb begin
        nx = ch_q[g];
        case (ch_q[g])
          annunciator_pkg::ch_normal:
            if (active[g]) nx = annunciator_pkg::ch_unacked;
          annunciator_pkg::ch_unacked:
            if (ack_cmd) nx = annunciator_pkg::ch_acked;
          annunciator_pkg::ch_acked:
            if (!active[g]) begin
              if (seq == annunciator_pkg::seq_ringback) nx = annunciator_pkg::ch_ringback;
              else if (!is_manual || reset_cmd) nx = annunciator_pkg::ch_normal;
            end
          annunciator_pkg::ch_ringback:
            if (active[g]) nx = annunciator_pkg::ch_unacked;
            else if (reset_cmd) nx = annunciator_pkg::ch_normal;
          default: nx = annunciator_pkg::ch_normal;
        endcase
      end
      always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) ch_q[g] <= annunciator_pkg::ch_normal;
        else ch_q[g] <= nx;
      end
      // Lamps: test overrides, steady sequence never flashes
      always_comb begin
        if (lamp_test_in) lamps_out[g] = 1'b1;
        else if (unacked[g] && seq != annunciator_pkg::seq_manual_steady) begin
          if (is_firstout && firstout_q[g]) lamps_out[g] =
            (seq == annunciator_pkg::seq_firstout_flash_reset) ? fast_q : flash_q;
          else if (is_firstout) lamps_out[g] = 1'b1;
          else lamps_out[g] = flash_q;
        end else if (ringing[g]) lamps_out[g] = fast_q;
        else lamps_out[g] = nonnormal[g];
      end
    end
  endgenerate

  // First-out capture and clear
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      firstout_q <= '0;
      firstout_set_q <= 1'b0;
      active_prev_q <= '0;
    end else begin
      active_prev_q <= active;
      if (!any_nonnormal && !(|new_trip)) begin
        firstout_q <= '0;
        firstout_set_q <= 1'b0;
      end else if (is_firstout && !firstout_taken && (|new_trip)) begin
        firstout_q <= first_pick;
        firstout_set_q <= 1'b1;
      end
    end
  end

  // Flash clocks
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flash_cnt_q <= '0;
      flash_q <= 1'b0;
      fast_q <= 1'b0;
    end else if (flash_cnt_q >= 32'(FLASH_CYCLES / 2 - 1)) begin
      flash_cnt_q <= '0;
      fast_q <= ~fast_q;
      if (fast_q) flash_q <= ~flash_q;
    end else flash_cnt_q <= flash_cnt_q + 32'h0000_0001;
  end

  // Horn: new alarm or ringback, silenced by acknowledge
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) horn_q <= 1'b0;
    else if (ack_cmd) horn_q <= 1'b0;
    else if (any_unacked || (|ringing)) horn_q <= 1'b1;
    else horn_q <= 1'b0;
  end
  assign horn_relay_out = horn_q;

  wire common_alarm = any_nonnormal | (|active) | link_alarm_in | fault;
  assign common_relay_out = common_alarm ~^ config_q[`CFG_COMMON_ENERGIZE_BIT];
  assign link_alarm_out = any_nonnormal | (|active) | fault;
  assign link_firstout_taken_out = firstout_set_q;
  assign link_ack_out = acknowledge_in;
  assign link_reset_out = reset_button_in;

  // Interrupt status: new trip, acknowledge, reset, fault
  // Held commands and faults keep setting their bit
  wire [3:0] events = {fault, reset_cmd, ack_cmd, |new_trip};
  wire rd_take = s_axi_arvalid & s_axi_arready;
  wire rd_status = rd_take & (s_axi_araddr == `ADDR_STATUS);
  assign irq_out = |(status_q & mask_q[3:0]);

  // AXI4-Lite slave
  wire wr_go = aw_got_q & w_got_q & ~s_axi_bvalid;
  wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire wr_hit = (awaddr_q == `ADDR_CONFIG) | (awaddr_q == `ADDR_POLARITY) |
                (awaddr_q == `ADDR_INT_MASK) | (awaddr_q == `ADDR_SERIAL);
  assign s_axi_awready = ~aw_got_q;
  assign s_axi_wready = ~w_got_q;
  assign s_axi_arready = ~s_axi_rvalid;

  wire [31:0] rd_mux =
    (s_axi_araddr == `ADDR_CONFIG) ? config_q :
    (s_axi_araddr == `ADDR_POLARITY) ? polarity_q :
    (s_axi_araddr == `ADDR_STATUS) ? {28'h0000000, status_q} :
    (s_axi_araddr == `ADDR_INT_MASK) ? mask_q :
    (s_axi_araddr == `ADDR_ALARMS) ? {4'h0, firstout_q, 4'h0, lamps_out} :
    (s_axi_araddr == `ADDR_SERIAL) ? serial_q : 32'h0000_0000;
  wire rd_hit = (s_axi_araddr <= `ADDR_SERIAL) & (s_axi_araddr[1:0] == 2'h0);

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid && !aw_got_q) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_got_q) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? 2'h0 : 2'h2;
      end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
      end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end
  end

  // Register writes; status set wins over read clear
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      config_q <= 32'h0000_0000;
      polarity_q <= 32'h0000_0000;
      mask_q <= 32'h0000_0000;
      serial_q <= `SERIAL_RESET;
      status_q <= 4'h0;
    end else begin
      status_q <= (rd_status ? 4'h0 : status_q) | events;
      if (wr_go && awaddr_q == `ADDR_CONFIG)
        config_q <= (config_q & ~wmask) | (wdata_q & wmask & 32'h0000_0037);
      if (wr_go && awaddr_q == `ADDR_POLARITY)
        polarity_q <= (polarity_q & ~wmask) | (wdata_q & wmask & 32'h0000_0FFF);
      if (wr_go && awaddr_q == `ADDR_INT_MASK)
        mask_q <= (mask_q & ~wmask) | (wdata_q & wmask & 32'h0000_000F);
      if (wr_go && awaddr_q == `ADDR_SERIAL)
        serial_q <= (serial_q & ~wmask) | (wdata_q & wmask & 32'h0000_3FFF);
    end
  end

  // Assertions
  horn_silenced_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    ack_cmd |=> !horn_relay_out) else $error("horn not silenced by acknowledge");
  horn_rings_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (any_unacked && !ack_cmd) |=> horn_relay_out) else $error("horn not sounding");
  test_lamps_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    lamp_test_in |-> (&lamps_out)) else $error("lamp test not lighting all");
  // Alarm level of the common relay equals the energize bit
  common_fault_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    fault |-> (common_relay_out == config_q[`CFG_COMMON_ENERGIZE_BIT]))
    else $error("fault did not trip common relay");
  trip_unacked_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (active[0] && ch_q[0] == annunciator_pkg::ch_normal) |=>
    ch_q[0] == annunciator_pkg::ch_unacked) else $error("trip not latched");
  manual_hold_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (is_manual && ch_q[0] == annunciator_pkg::ch_acked && !reset_cmd) |=>
    ch_q[0] != annunciator_pkg::ch_normal) else $error("manual cleared without reset");
  auto_clear_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (seq == annunciator_pkg::seq_auto_reset && ch_q[0] == annunciator_pkg::ch_acked &&
     !active[0]) |=> ch_q[0] == annunciator_pkg::ch_normal) else $error("auto reset stuck");
  steady_lamp_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (seq == annunciator_pkg::seq_manual_steady && unacked[0]) |-> lamps_out[0])
    else $error("steady lamp flashing");
  firstout_hold_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (firstout_set_q && any_nonnormal) |=> $stable(firstout_q))
    else $error("first-out changed while held");
  firstout_pick_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (is_firstout && !firstout_taken && (|new_trip)) |=> firstout_q == $past(first_pick))
    else $error("first-out not captured");
  firstout_one_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    $onehot0(firstout_q)) else $error("more than one first-out");
  ringback_go_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (seq == annunciator_pkg::seq_ringback && ch_q[0] == annunciator_pkg::ch_acked &&
     !active[0]) |=> ringing[0]) else $error("no ringback");
  common_alarm_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    any_nonnormal |-> (common_relay_out == config_q[`CFG_COMMON_ENERGIZE_BIT]))
    else $error("common relay missed alarm");
  cov_fault_c: cover property (@(posedge clock_in) disable iff (!reset_n_in)
    fault && common_relay_out);
  cov_trip_ack_c: cover property (@(posedge clock_in) disable iff (!reset_n_in)
    unacked[0] ##1 ch_q[0] == annunciator_pkg::ch_acked);
  cov_ringback_c: cover property (@(posedge clock_in) disable iff (!reset_n_in) ringing[0]);
  cov_firstout_c: cover property (@(posedge clock_in) disable iff (!reset_n_in)
    firstout_set_q && (|(unacked & ~firstout_q)));
endmodule : alarm_annunciator_sequencer
`default_nettype wire

// >>> test/field_side_model.sv
// Field side: alarm contacts and operator pushbuttons, plus a linked peer's acknowledge.
// Assumes the bench asks for levels just after a rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module field_side_model (
  input wire logic clock_in,
  input wire logic [11:0] contact_req_in,
  input wire logic [3:0] button_req_in,
  output logic [11:0] contacts_out = 12'h000,
  output logic ack_out = 1'b0,
  output logic test_out = 1'b0,
  output logic reset_out = 1'b0,
  output logic peer_ack_out = 1'b0
);
  // Contacts share one common pole; each is just a level
  always_ff @(posedge clock_in) begin
    contacts_out <= contact_req_in;
    ack_out <= button_req_in[0];
    test_out <= button_req_in[1];
    reset_out <= button_req_in[2];
    peer_ack_out <= button_req_in[3];
  end
endmodule : field_side_model
`default_nettype wire

// >>> test/alarm_annunciator_sequencer_tb.sv
// Self-checking bench for the alarm annunciator sequencer.
// Assumes the field model and an AXI4-Lite master task set drive the block.
`include "annunciator_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module alarm_annunciator_sequencer_tb;
  logic clock_in, reset_n_in, acknowledge_in, lamp_test_in, reset_button_in, link_ack_in;
  logic link_alarm_in, link_firstout_taken_in, link_reset_in, link_reset_out;
  logic [11:0] alarm_contact_inputs_in, lamps_out, cont_req, pol;
  logic [3:0] btn_req, s_axi_wstrb;
  logic link_alarm_out, link_firstout_taken_out, link_ack_out, horn_relay_out;
  logic common_relay_out, irq_out, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp_q;
  int err_count, tests_run, k, j, s, bad;
  int cycles = 0;
  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end
  field_side_model u_field_side_model (.clock_in, .contact_req_in(cont_req),
    .button_req_in(btn_req), .contacts_out(alarm_contact_inputs_in), .ack_out(acknowledge_in),
    .test_out(lamp_test_in), .reset_out(reset_button_in), .peer_ack_out(link_ack_in));
  alarm_annunciator_sequencer #(.CHANNELS(12), .FLASH_CYCLES(8)) u_alarm_annunciator_sequencer (
    .clock_in, .reset_n_in, .alarm_contact_inputs_in, .acknowledge_in, .lamp_test_in,
    .reset_button_in, .link_alarm_in, .link_firstout_taken_in, .link_ack_in,
    .link_reset_in, .link_alarm_out, .link_firstout_taken_out, .link_ack_out,
    .link_reset_out, .lamps_out, .horn_relay_out, .common_relay_out, .irq_out,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  function automatic logic relay_exp(input logic alarm, input logic energize);
    return energize ? alarm : !alarm;
  endfunction : relay_exp
  task chk(input string n, input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, want, seen);
    end
  endtask : chk
  task report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  // Handshakes taken at the rising edge where valid and ready meet
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_busy, w_busy, b_wait;
    @(posedge clock_in);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw_busy = 1'b1;
    w_busy = 1'b1;
    b_wait = 1'b1;
    while (b_wait) begin
      @(posedge clock_in);
      if (aw_busy && s_axi_awready) begin
        aw_busy = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_busy && s_axi_wready) begin
        w_busy = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid) begin
        b_wait = 1'b0;
        resp_q = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
    @(negedge clock_in);
  endtask : wr
  task rd(input logic [7:0] a);
    logic ar_busy, r_wait;
    @(posedge clock_in);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    ar_busy = 1'b1;
    r_wait = 1'b1;
    while (r_wait) begin
      @(posedge clock_in);
      if (ar_busy && s_axi_arready) begin
        ar_busy = 1'b0;
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_rvalid) begin
        r_wait = 1'b0;
        rd_q = s_axi_rdata;
        resp_q = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
    @(negedge clock_in);
  endtask : rd
  task push(input logic [3:0] b);
    @(posedge clock_in);
    btn_req <= b;
    repeat (3) @(posedge clock_in);
    btn_req <= 4'h0;
    repeat (4) @(negedge clock_in);
  endtask : push
  task trip(input logic [11:0] bits);
    @(posedge clock_in);
    cont_req <= pol ^ bits;
  endtask : trip
  // Flashing lamps are only lit half the time, so look across a window
  task lamp_is(input logic v, input string n);
    logic hit;
    hit = 1'b0;
    repeat (40) begin
      @(negedge clock_in);
      if (lamps_out[k] === v) hit = 1'b1;
    end
    chk(n, hit, 1'b1);
  endtask : lamp_is
  task clear_all;
    push(4'h1);
    trip(12'h000);
    push(4'h4);
    rd(`ADDR_STATUS);
  endtask : clear_all
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_count++;
      report_and_stop();
    end
  end
  initial begin
    {cont_req, pol, btn_req, s_axi_wstrb, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {link_alarm_in, link_firstout_taken_in, link_reset_in} = '0;
    {reset_n_in, err_count, tests_run} = '0;
    void'($urandom(32'h6B0A));
    repeat (10) @(posedge clock_in);
    reset_n_in <= 1'b1;
    s_axi_wstrb <= 4'hF;
    rd(`ADDR_SERIAL);
    chk("serial", rd_q, `SERIAL_RESET);
    rd(8'h3C);
    chk("unmapped rresp", resp_q, 32'h2);
    for (s = 0; s < 7; s++) begin
      wr(`ADDR_CONFIG, s);
      rd(`ADDR_CONFIG);
      chk("sequence", rd_q[2:0], s);
    end
    pol = 12'($urandom);
    wr(`ADDR_POLARITY, {20'h0, pol});
    // New rest levels trip some channels until cleared
    clear_all();
    wr(`ADDR_INT_MASK, 32'h1);
    wr(`ADDR_CONFIG, 32'h1);
    chk("rest lamps", lamps_out, 32'h0);
    chk("rest relay", common_relay_out, relay_exp(1'b0, 1'b0));
    k = $urandom % 12;
    trip(12'h001 << k);
    lamp_is(1'b1, "manual trip lamp");
    chk("horn", horn_relay_out, 1'b1);
    chk("alarm relay", common_relay_out, relay_exp(1'b1, 1'b0));
    chk("link alarm", link_alarm_out, 1'b1);
    chk("irq", irq_out, 1'b1);
    rd(`ADDR_STATUS);
    chk("status trip", rd_q[0], 1'b1);
    @(negedge clock_in);
    chk("irq cleared", irq_out, 1'b0);
    push(4'h1);
    chk("ack horn", horn_relay_out, 1'b0);
    trip(12'h000);
    repeat (6) @(negedge clock_in);
    chk("manual held", lamps_out[k], 1'b1);
    chk("unreset relay", common_relay_out, relay_exp(1'b1, 1'b0));
    push(4'h4);
    lamp_is(1'b0, "manual reset lamp");
    rd(`ADDR_STATUS);
    k = 0; // Corner: channel 0 carries the per-channel assertions
    wr(`ADDR_INT_MASK, 32'h0);
    wr(`ADDR_CONFIG, 32'h0);
    trip(12'h001 << k);
    lamp_is(1'b1, "auto trip lamp");
    chk("masked irq", irq_out, 1'b0);
    push(4'h1);
    trip(12'h000);
    lamp_is(1'b0, "auto clear lamp");
    wr(`ADDR_CONFIG, 32'h3);
    trip(12'h001 << k);
    repeat (3) @(negedge clock_in);
    bad = 0;
    repeat (24) begin
      @(negedge clock_in);
      if (lamps_out[k] !== 1'b1) bad++;
    end
    chk("steady lamp", bad, 32'h0);
    clear_all();
    wr(`ADDR_CONFIG, 32'h2);
    trip(12'h001 << k);
    lamp_is(1'b1, "ringback trip");
    push(4'h1);
    trip(12'h000);
    repeat (5) @(negedge clock_in);
    chk("ringback horn", horn_relay_out, 1'b1);
    clear_all();
    lamp_is(1'b0, "ringback reset");
    for (s = 4; s < 7; s++) begin
      wr(`ADDR_CONFIG, s);
      j = (k + 1 + $urandom % 11) % 12;
      trip(12'h001 << k);
      repeat (4) @(posedge clock_in);
      trip((12'h001 << k) | (12'h001 << j));
      repeat (4) @(posedge clock_in);
      rd(`ADDR_ALARMS);
      chk("first out", rd_q[27:16], 12'h001 << k);
      chk("link first out", link_firstout_taken_out, 1'b1);
      chk("later lamp steady", lamps_out[j], 1'b1);
      clear_all();
      rd(`ADDR_ALARMS);
      chk("first out cleared", rd_q, 32'h0);
    end
    wr(`ADDR_CONFIG, 32'h1);
    trip(12'h001 << k);
    lamp_is(1'b1, "peer trip");
    push(4'h8);
    chk("peer ack horn", horn_relay_out, 1'b0);
    clear_all();
    wr(`ADDR_CONFIG, 32'h5);
    @(posedge clock_in);
    link_alarm_in <= 1'b1;
    link_firstout_taken_in <= 1'b1;
    @(negedge clock_in);
    chk("link relay", common_relay_out, relay_exp(1'b1, 1'b0));
    trip(12'h001 << k);
    repeat (4) @(negedge clock_in);
    chk("peer first out held", link_firstout_taken_out, 1'b0);
    push(4'h1);
    trip(12'h000);
    @(posedge clock_in);
    {link_alarm_in, link_firstout_taken_in, link_reset_in} <= 3'h1;
    repeat (3) @(posedge clock_in);
    link_reset_in <= 1'b0;
    lamp_is(1'b0, "link reset lamp");
    push(4'h0);
    @(posedge clock_in);
    btn_req <= 4'h7;
    repeat (3) @(negedge clock_in);
    chk("lamp test", lamps_out, 32'hFFF);
    chk("link ack", link_ack_out, 1'b1);
    chk("link reset", link_reset_out, 1'b1);
    wr(`ADDR_CONFIG, 32'h20);
    chk("fault relay", common_relay_out, relay_exp(1'b1, 1'b0));
    wr(`ADDR_CONFIG, 32'h30);
    chk("fault energize", common_relay_out, relay_exp(1'b1, 1'b1));
    report_and_stop();
  end
endmodule : alarm_annunciator_sequencer_tb
`default_nettype wire
